// *** hw/visel_top.sv ***
`timescale 1ns/100ps
module visel_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt sources
  input  wire logic [31:0] fixed_intr,
  input  wire logic [15:0] dma_term_out_low_group,
  input  wire logic [15:0] dma_term_out_high_group,
  input  wire logic [31:0] logic_array_intr,
  // core side
  output logic             core_irq,
  output logic [4:0]       core_vector,
  output logic [15:0]      core_isr_addr,
  input  wire logic        core_irq_acknowledge,
  input  wire logic        core_handler_return,
  // summary interrupt
  output logic             irq_out
);
  // ==========================================================
  // state
  logic [31:0] enable_reg;
  logic [31:0] pending_flag_reg;
  logic [31:0] posted_flag_reg;
  logic [31:0] src_prev_reg;
  logic [31:0] prio_reg [4];
  logic [31:0] srcsel_reg [2];
  logic [15:0] vaddr_reg [32];
  logic [7:0]  active_reg;
  logic [1:0]  evstat_reg;
  logic [1:0]  evmask_reg;
  logic [2:0]  stg_valid_reg;
  logic [4:0]  stg_vec_reg [3];
  logic [2:0]  stg_lvl_reg [3];
  logic [15:0] isr_addr_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  visel_arb_if arb_bus ();

  visel_arb u_arb (
    .arb (arb_bus.arb_side)
  );

  // ==========================================================
  // source selection
  logic [31:0] fixed_line;
  logic [31:0] dma_line;
  logic [31:0] src_line;
  logic [31:0] src_rise;
  logic [95:0] prio_flat;

  assign fixed_line = fixed_intr & visel_pkg::FIXED_USED;
  assign dma_line   = {dma_term_out_high_group, dma_term_out_low_group};

  generate
    for (genvar v = 0; v < visel_pkg::NVEC; v++) begin : g_vec
      logic [1:0] sel;
      assign sel = srcsel_reg[v / visel_pkg::SEL_PER_W]
                   [(v % visel_pkg::SEL_PER_W) * visel_pkg::SEL_FW +: 2];
      assign src_line[v] =
        (sel == visel_pkg::SRC_FIXED) ? fixed_line[v] :
        (sel == visel_pkg::SRC_DMA)   ? dma_line[v] :
        (sel == visel_pkg::SRC_LOGIC) ? logic_array_intr[v] :
        1'b0;
      assign prio_flat[v*3 +: 3] = prio_reg[v / visel_pkg::PRIO_PER_W]
                   [(v % visel_pkg::PRIO_PER_W) * visel_pkg::PRIO_FW +: 3];
    end
  endgenerate

  assign src_rise = src_line & ~src_prev_reg;

  // ==========================================================
  // nesting ceiling: highest active level blocks equal and lower
  logic [3:0] ceiling;
  logic [7:0] active_lowest;

  always_comb begin
    ceiling = 4'h8;
    for (int l = visel_pkg::NLVL - 1; l >= 0; l--) begin
      if (active_reg[l]) begin
        ceiling = 4'(l);
      end
    end
  end

  assign active_lowest = active_reg & (~active_reg + 8'h01);

  assign arb_bus.posted  = posted_flag_reg;
  assign arb_bus.prio    = prio_flat;
  assign arb_bus.ceiling = ceiling;

  // ==========================================================
  // core handshake
  logic        ack_take;
  logic [31:0] ack_clear;
  logic        hold_pipe;

  assign core_irq      = stg_valid_reg[2] & posted_flag_reg[stg_vec_reg[2]];
  assign core_vector   = stg_vec_reg[2];
  assign core_isr_addr = isr_addr_reg;
  assign ack_take      = core_irq_acknowledge & stg_valid_reg[2];
  assign ack_clear     = ack_take ? (32'h0000_0001 << stg_vec_reg[2]) : 32'h0000_0000;
  assign hold_pipe     = core_irq & ~core_irq_acknowledge;

  // ==========================================================
  // axi write decode
  logic        do_write;
  logic        w_vaddr;
  logic        w_mapped;
  logic [31:0] wmask;
  logic [31:0] wval;

  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wmask    = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                     {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign wval     = w_data_reg & wmask;
  assign w_vaddr  = aw_addr_reg[11:7] == visel_pkg::OFS_VADDR0[11:7];
  assign w_mapped = w_vaddr || (aw_addr_reg <= visel_pkg::OFS_EVMASK);

  function automatic logic wr_at(input logic [11:0] ofs);
    wr_at = do_write && (aw_addr_reg[11:2] == ofs[11:2]);
  endfunction : wr_at

  logic [31:0] sw_pending_flag_clr;
  logic [31:0] sw_pending_flag_set;
  logic [1:0]  ev_clr;
  logic [1:0]  ev_set;

  assign sw_pending_flag_clr = wr_at(visel_pkg::OFS_PENDING_FLAG) ? wval : 32'h0000_0000;
  assign sw_pending_flag_set = wr_at(visel_pkg::OFS_SETPEND) ? wval : 32'h0000_0000;
  assign ev_clr      = wr_at(visel_pkg::OFS_EVSTAT) ? wval[1:0] : 2'h0;
  assign ev_set      = {core_handler_return, ack_take};

  // ==========================================================
  // axi handshakes
  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready  = ~w_held_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign irq_out       = |(evstat_reg & evmask_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= visel_pkg::RESP_OKAY;
      aw_addr_reg <= 12'h000;
      w_data_reg  <= visel_pkg::RST_WORD;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= w_mapped ? visel_pkg::RESP_OKAY : visel_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read mux
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [11:0] ra;

  assign ra = s_axi_araddr;

  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    if (ra[11:7] == visel_pkg::OFS_VADDR0[11:7]) begin
      rd_word = {16'h0000, vaddr_reg[ra[6:2]]};
    end else begin
      case (ra[11:2])
        visel_pkg::OFS_ENABLE[11:2]:  rd_word = enable_reg;
        visel_pkg::OFS_PENDING_FLAG[11:2]:    rd_word = pending_flag_reg;
        visel_pkg::OFS_SETPEND[11:2]: rd_word = 32'h0000_0000;
        visel_pkg::OFS_POSTED[11:2]:  rd_word = posted_flag_reg;
        visel_pkg::OFS_PRIO0[11:2]:   rd_word = prio_reg[0];
        10'(visel_pkg::OFS_PRIO0[11:2] + 10'h1): rd_word = prio_reg[1];
        10'(visel_pkg::OFS_PRIO0[11:2] + 10'h2): rd_word = prio_reg[2];
        10'(visel_pkg::OFS_PRIO0[11:2] + 10'h3): rd_word = prio_reg[3];
        visel_pkg::OFS_SRCSEL0[11:2]: rd_word = srcsel_reg[0];
        10'(visel_pkg::OFS_SRCSEL0[11:2] + 10'h1): rd_word = srcsel_reg[1];
        visel_pkg::OFS_ACTIVE[11:2]:
          rd_word = {16'h0000, active_reg, core_irq, 2'h0, core_vector};
        visel_pkg::OFS_EVSTAT[11:2]:  rd_word = {30'h0, evstat_reg};
        visel_pkg::OFS_EVMASK[11:2]:  rd_word = {30'h0, evmask_reg};
        default:                      rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= visel_pkg::RESP_OKAY;
      rdata_reg  <= visel_pkg::RST_WORD;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_ok ? visel_pkg::RESP_OKAY : visel_pkg::RESP_SLVERR;
      rdata_reg  <= rd_ok ? rd_word : 32'h0000_0000;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg <= visel_pkg::RST_WORD;
      evmask_reg <= 2'h0;
      for (int i = 0; i < 4; i++) prio_reg[i] <= visel_pkg::RST_WORD;
      for (int i = 0; i < 2; i++) srcsel_reg[i] <= visel_pkg::RST_WORD;
    end else begin
      if (wr_at(visel_pkg::OFS_ENABLE))
        enable_reg <= (enable_reg & ~wmask) | wval;
      if (wr_at(visel_pkg::OFS_EVMASK))
        evmask_reg <= (evmask_reg & ~wmask[1:0]) | wval[1:0];
      for (int i = 0; i < 4; i++)
        if (wr_at(12'(visel_pkg::OFS_PRIO0 + 12'(4 * i))))
          prio_reg[i] <= (prio_reg[i] & ~wmask) | wval;
      for (int i = 0; i < 2; i++)
        if (wr_at(12'(visel_pkg::OFS_SRCSEL0 + 12'(4 * i))))
          srcsel_reg[i] <= (srcsel_reg[i] & ~wmask) | wval;
    end
  end

  // handler address table, no reset needed for contents
  always_ff @(posedge aclk) begin
    if (do_write && w_vaddr)
      vaddr_reg[aw_addr_reg[6:2]] <= (vaddr_reg[aw_addr_reg[6:2]] & ~wmask[15:0]) | wval[15:0];
  end

  // ==========================================================
  // pending and posted flags; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_prev_reg     <= 32'h0000_0000;
      pending_flag_reg <= 32'h0000_0000;
      posted_flag_reg  <= 32'h0000_0000;
      evstat_reg       <= 2'h0;
    end else begin
      src_prev_reg     <= src_line;
      pending_flag_reg <= (pending_flag_reg & ~ack_clear & ~sw_pending_flag_clr)
                          | src_rise | sw_pending_flag_set;
      posted_flag_reg  <= pending_flag_reg & enable_reg;
      evstat_reg       <= (evstat_reg & ~ev_clr) | ev_set;
    end
  end

  // ==========================================================
  // three-stage evaluation and nesting
  always_ff @(posedge aclk) begin
    if (!aresetn || ack_take) begin
      stg_valid_reg <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        stg_vec_reg[i] <= 5'h00;
        stg_lvl_reg[i] <= 3'h0;
      end
      if (!aresetn) isr_addr_reg <= 16'h0000;
    end else if (!hold_pipe) begin
      stg_valid_reg  <= {stg_valid_reg[1:0], arb_bus.valid};
      stg_vec_reg[0] <= arb_bus.vector;
      stg_lvl_reg[0] <= arb_bus.level;
      for (int i = 1; i < 3; i++) begin
        stg_vec_reg[i] <= stg_vec_reg[i-1];
        stg_lvl_reg[i] <= stg_lvl_reg[i-1];
      end
      isr_addr_reg <= vaddr_reg[stg_vec_reg[1]];
    end
  end

  // core stacks counter and pops it on return; only the levels are tracked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_reg <= 8'h00;
    end else begin
      active_reg <= (active_reg & ~(core_handler_return ? active_lowest : 8'h00))
                    | (ack_take ? (8'h01 << stg_lvl_reg[2]) : 8'h00);
    end
  end
endmodule : visel_top

// *** shared/visel_pkg.sv ***
// ==========================================================
// vector selector constants
package visel_pkg;
  localparam int          NVEC       = 32;
  localparam int          NLVL       = 8;
  localparam int          AW         = 12;
  localparam int          EVAL_STAGES = 3;
  // ==========================================================
  // register byte offsets
  localparam logic [11:0] OFS_ENABLE  = 12'h000;
  localparam logic [11:0] OFS_PENDING_FLAG    = 12'h004;
  localparam logic [11:0] OFS_SETPEND = 12'h008;
  localparam logic [11:0] OFS_POSTED  = 12'h00c;
  localparam logic [11:0] OFS_PRIO0   = 12'h010;
  localparam logic [11:0] OFS_SRCSEL0 = 12'h020;
  localparam logic [11:0] OFS_ACTIVE  = 12'h028;
  localparam logic [11:0] OFS_EVSTAT  = 12'h02c;
  localparam logic [11:0] OFS_EVMASK  = 12'h030;
  localparam logic [11:0] OFS_VADDR0  = 12'h080;
  // ==========================================================
  // field layout
  localparam int          PRIO_FW     = 4;
  localparam int          PRIO_PER_W  = 8;
  localparam int          SEL_FW      = 2;
  localparam int          SEL_PER_W   = 16;
  localparam int          EV_DISPATCH = 0;
  localparam int          EV_RETURN   = 1;
  localparam int          ACT_VEC_LSB = 0;
  localparam int          ACT_IRQ_BIT = 7;
  localparam int          ACT_LVL_LSB = 8;
  // ==========================================================
  // reset values and encodings
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [31:0] FIXED_USED  = 32'hfbff_fffb;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SRC_FIXED = 2'h0,
    SRC_DMA   = 2'h1,
    SRC_LOGIC = 2'h2,
    SRC_NONE  = 2'h3
  } visel_src_t;
endpackage : visel_pkg

// *** shared/visel_arb_if.sv ***
`timescale 1ns/100ps
// ==========================================================
// posted vectors in, winner out
interface visel_arb_if;
  logic [31:0] posted;
  logic [95:0] prio;
  logic [3:0]  ceiling;
  logic        valid;
  logic [4:0]  vector;
  logic [2:0]  level;
  modport top_side (output posted, output prio, output ceiling,
                    input valid, input vector, input level);
  modport arb_side (input posted, input prio, input ceiling,
                    output valid, output vector, output level);
endinterface : visel_arb_if

// *** hw/visel_arb.sv ***
`timescale 1ns/100ps
// ==========================================================
// combinational priority pick
module visel_arb (
  // winner selection
  visel_arb_if.arb_side arb
);
  logic [4:0] best_vec;
  logic [2:0] best_lvl;
  logic       best_ok;

  always_comb begin
    best_vec = 5'h00;
    best_lvl = 3'h7;
    best_ok  = 1'b0;
    // descending scan with <= so the lower vector wins ties
    for (int v = visel_pkg::NVEC - 1; v >= 0; v--) begin
      if (arb.posted[v] && ({1'b0, arb.prio[v*3 +: 3]} < arb.ceiling) &&
          (!best_ok || arb.prio[v*3 +: 3] <= best_lvl)) begin
        best_ok  = 1'b1;
        best_vec = 5'(v);
        best_lvl = arb.prio[v*3 +: 3];
      end
    end
  end

  assign arb.valid  = best_ok;
  assign arb.vector = best_vec;
  assign arb.level  = best_lvl;
endmodule : visel_arb

// *** bench/visel_core_model.sv ***
`timescale 1ns/100ps
// ==========================================================
// processor core stand-in: acks, jumps, returns
module visel_core_model (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // request from controller
  input  wire logic        core_irq,
  input  wire logic [15:0] core_isr_addr,
  // cycles spent finishing the current instruction
  input  wire logic [3:0]  ack_wait,
  // answers to controller
  output logic             ack,
  output logic             ret
);
  logic [1:0]  st_reg;
  logic [3:0]  cnt_reg;
  logic [15:0] pc_reg;
  logic [15:0] stk_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg  <= 2'h0;
      cnt_reg <= 4'h0;
      ack     <= 1'b0;
      ret     <= 1'b0;
      pc_reg  <= 16'h0100;
      stk_reg <= 16'h0000;
    end else begin
      ack     <= 1'b0;
      ret     <= 1'b0;
      pc_reg  <= pc_reg + 16'h0001;
      cnt_reg <= cnt_reg + 4'h1;
      if (st_reg == 2'h0) begin
        if (!core_irq) cnt_reg <= 4'h0;
        if (core_irq && cnt_reg >= ack_wait) begin
          ack     <= 1'b1;
          stk_reg <= pc_reg + 16'h0001;
          pc_reg  <= core_isr_addr;
          st_reg  <= 2'h1;
          cnt_reg <= 4'h0;
        end
      end else if (cnt_reg == 4'h6) begin
        ret    <= 1'b1;
        pc_reg <= stk_reg;
        st_reg <= 2'h0;
      end
    end
  end
endmodule : visel_core_model

// *** bench/visel_top_assertions.sv ***
`timescale 1ns/100ps
// ==========================================================
// port checker
module visel_top_assertions (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // bus answers
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // core side
  input  wire logic        core_irq,
  input  wire logic [4:0]  core_vector,
  input  wire logic [15:0] core_isr_addr,
  input  wire logic        core_irq_acknowledge,
  input  wire logic        core_handler_return,
  input  wire logic        irq_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  irq_hold_a: assert property (core_irq && !core_irq_acknowledge |=> core_irq
    && $stable(core_vector) && $stable(core_isr_addr)) else $error("request not held");
  ack_drop_a: assert property (core_irq && core_irq_acknowledge |=> !core_irq [*3])
    else $error("request not cleared by ack");
  irq_drop_a: assert property ($fell(core_irq) |-> $past(core_irq_acknowledge))
    else $error("request dropped without ack");
  eval_gap_a: assert property ($rose(core_irq) |-> !$past(core_irq, 2)
    && !$past(core_irq, 3)) else $error("request faster than evaluation");
  rst_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !core_irq
    && core_vector == 5'h00 && !irq_out && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read address not answered");

  ack_seen_c: cover property (core_irq && core_irq_acknowledge);
  ret_seen_c: cover property (core_handler_return);
  slverr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  irq_out_c: cover property ($rose(irq_out));
endmodule : visel_top_assertions

bind visel_top visel_top_assertions chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .core_irq(core_irq),
  .core_vector(core_vector), .core_isr_addr(core_isr_addr), .irq_out(irq_out),
  .core_irq_acknowledge(core_irq_acknowledge), .core_handler_return(core_handler_return));

// *** bench/visel_top_tb.sv ***
`timescale 1ns/100ps
module visel_top_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, core_irq, ack, ret, irq_out;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, fixed_intr, logic_array_intr;
  logic [15:0] dma_lo, dma_hi, core_isr_addr;
  logic [1:0]  bresp, rresp;
  logic [4:0]  core_vector;
  logic [3:0]  ack_wait;
  logic [4:0]  got_v[$];
  logic [15:0] got_a[$];
  int fail_count = 0;
  int samples_checked = 0;

  visel_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fixed_intr(fixed_intr), .dma_term_out_low_group(dma_lo), .dma_term_out_high_group(dma_hi),
    .logic_array_intr(logic_array_intr), .core_irq(core_irq), .core_vector(core_vector),
    .core_isr_addr(core_isr_addr), .core_irq_acknowledge(ack), .core_handler_return(ret),
    .irq_out(irq_out));
  visel_core_model core_u (.aclk(aclk), .aresetn(aresetn), .core_irq(core_irq),
    .core_isr_addr(core_isr_addr), .ack_wait(ack_wait), .ack(ack), .ret(ret));

  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (ack === 1'b1 && core_irq === 1'b1) begin
      got_v.push_back(core_vector);
      got_a.push_back(core_isr_addr);
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", what, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic er = 1'b0,
                        input int lag = 0);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready === 1'b1) begin
        bready <= 1'b0;
        chk($sformatf("bresp@%h", a), er ? 32'h2 : 32'h0, 32'(bresp));
        done = 1'b1;
      end else if (n + 1 >= lag) begin
        bready <= 1'b1;
      end
    end
    if (!done) chk("write answer", 32'h1, 32'h0);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic er = 1'b0,
                        input int lag = 0);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready === 1'b1) begin
        rready <= 1'b0;
        chk($sformatf("rdata@%h", a), ed, rdata);
        chk($sformatf("rresp@%h", a), er ? 32'h2 : 32'h0, 32'(rresp));
        done = 1'b1;
      end else if (n + 1 >= lag) begin
        rready <= 1'b1;
      end
    end
    if (!done) chk("read answer", 32'h1, 32'h0);
  endtask : axi_rd

  task automatic drive(input int v, input logic [1:0] sel, input logic val);
    case (sel)
      visel_pkg::SRC_DMA: if (v < 16) dma_lo[v] <= val; else dma_hi[v - 16] <= val;
      visel_pkg::SRC_LOGIC: logic_array_intr[v] <= val;
      default: fixed_intr[v] <= val;
    endcase
  endtask : drive

  task automatic wait_ret();
    int n;
    for (n = 0; n < 60 && ret !== 1'b1; n++) @(posedge aclk);
    chk("return", 32'h1, 32'(ret));
  endtask : wait_ret

  task automatic reset_values();
    logic [11:0] ofs[8] = '{visel_pkg::OFS_ENABLE, visel_pkg::OFS_PENDING_FLAG, visel_pkg::OFS_POSTED,
      visel_pkg::OFS_PRIO0, visel_pkg::OFS_SRCSEL0, visel_pkg::OFS_ACTIVE,
      visel_pkg::OFS_EVSTAT, visel_pkg::OFS_EVMASK};
    chk("core_irq", 32'h0, 32'(core_irq));
    foreach (ofs[i]) axi_rd(ofs[i], visel_pkg::RST_WORD);
  endtask : reset_values

  task automatic fire(input int v, input logic [1:0] sel, input logic exp);
    int n, b;
    logic [15:0] va;
    va = 16'ha500 + 16'(v);
    axi_wr(visel_pkg::OFS_VADDR0 + 12'(4 * v), {16'h0000, va});
    axi_wr(visel_pkg::OFS_SRCSEL0 + 12'(4 * (v / 16)), 32'(sel) << (2 * (v % 16)));
    axi_wr(visel_pkg::OFS_ENABLE, 32'h1 << v);
    b = got_v.size();
    @(posedge aclk);
    drive(v, sel, 1'b1);
    for (n = 0; n < 24 && core_irq !== 1'b1; n++) begin
      @(posedge aclk);
      drive(v, sel, 1'b0);
      #1;
    end
    if (exp) begin
      chk("latency", 32'd5, 32'(n));
      for (n = 0; n < 40 && got_v.size() == b; n++) @(posedge aclk);
      chk("ack seen", 32'(b + 1), 32'(got_v.size()));
      chk("vector", 32'(v), 32'(got_v[b]));
      chk("handler", 32'(va), 32'(got_a[b]));
      wait_ret();
      axi_rd(visel_pkg::OFS_PENDING_FLAG, 32'h0);
      axi_rd(visel_pkg::OFS_POSTED, 32'h0);
    end else begin
      chk("no request", 32'(b), 32'(got_v.size()));
    end
    axi_wr(visel_pkg::OFS_ENABLE, 32'h0);
  endtask : fire

  task automatic tie_break();
    int b, n;
    int ord[3] = '{20, 3, 9};
    ack_wait <= 4'h4;
    axi_wr(visel_pkg::OFS_PRIO0, 32'h0000_2000);
    axi_wr(visel_pkg::OFS_PRIO0 + 12'h004, 32'h0000_0020);
    axi_wr(visel_pkg::OFS_PRIO0 + 12'h008, 32'h0001_0000);
    axi_rd(visel_pkg::OFS_PRIO0 + 12'h008, 32'h0001_0000);
    foreach (ord[i]) axi_wr(visel_pkg::OFS_VADDR0 + 12'(4 * ord[i]), 32'h0000_0b00);
    b = got_v.size();
    axi_wr(visel_pkg::OFS_ENABLE, 32'h0010_0208);
    axi_wr(visel_pkg::OFS_SETPEND, 32'h0010_0208);
    for (n = 0; n < 300 && got_v.size() < b + 3; n++) @(posedge aclk);
    foreach (ord[i]) chk("order", 32'(ord[i]), 32'(got_v[b + i]));
    wait_ret();
    axi_wr(visel_pkg::OFS_ENABLE, 32'h0);
    ack_wait <= 4'h0;
  endtask : tie_break

  task automatic events();
    chk("irq_out masked", 32'h0, 32'(irq_out));
    axi_rd(visel_pkg::OFS_EVSTAT, 32'h3);
    axi_wr(visel_pkg::OFS_EVMASK, 32'h1, 1'b0, 3);
    chk("irq_out raised", 32'h1, 32'(irq_out));
    axi_wr(visel_pkg::OFS_EVSTAT, 32'h1);
    chk("irq_out cleared", 32'h0, 32'(irq_out));
    axi_rd(visel_pkg::OFS_EVSTAT, 32'h2, 1'b0, 3);
    axi_wr(visel_pkg::OFS_EVSTAT, 32'h2);
    axi_rd(visel_pkg::OFS_EVSTAT, 32'h0);
    axi_wr(visel_pkg::OFS_SETPEND, 32'h0000_0040);
    axi_rd(visel_pkg::OFS_PENDING_FLAG, 32'h0000_0040);
    axi_wr(visel_pkg::OFS_PENDING_FLAG, 32'h0000_0040);
    axi_rd(visel_pkg::OFS_PENDING_FLAG, 32'h0000_0000);
    axi_rd(12'h040, 32'h0, 1'b1);
    axi_wr(12'h044, 32'hffff_ffff, 1'b1);
  endtask : events

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  initial begin
    #200000;
    fail_count++;
    close_out();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, fixed_intr, logic_array_intr, dma_lo, dma_hi} = '0;
    ack_wait = 4'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    reset_values();
    fire(5, visel_pkg::SRC_FIXED, 1'b1);
    fire(31, visel_pkg::SRC_FIXED, 1'b1);
    fire(0, visel_pkg::SRC_DMA, 1'b1);
    fire(15, visel_pkg::SRC_DMA, 1'b1);
    fire(16, visel_pkg::SRC_DMA, 1'b1);
    fire(31, visel_pkg::SRC_DMA, 1'b1);
    fire(7, visel_pkg::SRC_LOGIC, 1'b1);
    fire(31, visel_pkg::SRC_LOGIC, 1'b1);
    fire(2, visel_pkg::SRC_FIXED, 1'b0);
    fire(26, visel_pkg::SRC_FIXED, 1'b0);
    fire(26, visel_pkg::SRC_LOGIC, 1'b1);
    fire(5, visel_pkg::SRC_NONE, 1'b0);
    tie_break();
    events();
    close_out();
  end
endmodule : visel_top_tb
